/* File: testbench/asram_host_tb_top.sv */
// Self-checking bench for the static RAM host controller, fast grade.
// Assumes the behavioural RAM model on the pins; bus is resolved here.
`timescale 1ns/1ps
`default_nettype none

module asram_host_tb_top;
  import asram_pkg::*;
  logic ref_clk_in, sys_rst_in, req_valid_in, retain_in;
  asram_req_t req_in;
  asram_pins_t pins;
  logic req_ready, rdata_valid, retained, host_oe_n, ram_drive;
  logic [DATA_W-1:0] rdata, host_dout, ram_dout, bus;
  int errors = 0;
  int num_checks = 0;
  // ==========================================================
  // Clock, bus resolution, design and far side
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  assign bus = !host_oe_n ? host_dout : ram_dout;
  asram_host i_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready), .rdata_out(rdata), .rdata_valid_out(rdata_valid),
    .retain_in(retain_in), .retained_out(retained), .pins_out(pins), .data_lines_in(bus),
    .data_lines_out(host_dout), .data_lines_oe_n_out(host_oe_n));
  asram_ram_model i_ram (.pins_in(pins), .bus_in(bus), .dout_out(ram_dout), .drive_out(ram_drive));

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bounded wait for the user side to accept
  task automatic wait_ready();
    int n;
    for (n = 0; n < 30 && req_ready !== 1'b1; n++)
      @(negedge ref_clk_in);
    chk("ready", 1, req_ready);
  endtask : wait_ready

  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int low;
    int n;
    low = 0;
    wait_ready();
    req_in = '{1'b1, a, d};
    req_valid_in = 1'b1;
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
    for (n = 0; n < 20 && req_ready !== 1'b1; n++)
    begin
      if (pins.chip_select_n === 1'b0 && pins.read_write === 1'b0)
        low++;
      @(negedge ref_clk_in);
    end
    chk("select low long enough", 1, low * CLK_PERIOD_NS >= SELECT_TO_WRITE_END_NS_FAST);
  endtask : do_write

  task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    wait_ready();
    req_in = '{1'b0, a, 8'h00};
    req_valid_in = 1'b1;
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
    for (n = 0; n < 20 && rdata_valid !== 1'b1; n++)
    begin
      @(negedge ref_clk_in);
      if (pins.chip_select_n === 1'b0)
        chk("read keeps rw high", 1, pins.read_write);
    end
    chk("read latency", 1, n >= 7 && n <= 12);
    chk("read byte", exp, rdata);
  endtask : do_read

  // Deselect for retention; requests refused, recovery before access
  task automatic do_retain();
    int n;
    retain_in = 1'b1;
    req_in = '{1'b0, 15'h0000, 8'h00};
    req_valid_in = 1'b1;
    @(negedge ref_clk_in);
    chk("retained", 1, retained);
    for (n = 0; n < 6; n++)
    begin
      chk("deselected", 1, pins.chip_select_n);
      @(negedge ref_clk_in);
    end
    req_valid_in = 1'b0;
    retain_in = 1'b0;
    for (n = 0; n < 12 && req_ready !== 1'b1; n++)
    begin
      chk("recovery deselected", 1, pins.chip_select_n);
      @(negedge ref_clk_in);
    end
    chk("recovery time", 1, n * CLK_PERIOD_NS >= READ_CYCLE_NS_FAST && n <= 8);
    chk("retention left", 0, retained);
  endtask : do_retain

  // Host and RAM never drive together
  always @(negedge ref_clk_in)
    if (!sys_rst_in && host_oe_n === 1'b0 && ram_drive === 1'b1)
      chk("bus contention", 0, 1);

  initial
  begin
    #100us;
    chk("watchdog", 0, 1);
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    sys_rst_in = 1'b1;
    req_valid_in = 1'b0;
    retain_in = 1'b0;
    req_in = '0;
    repeat (12) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    chk("reset pins", {3'h0, 15'h0000, 3'h7, 3'h1}, {3'h0, pins, 2'h0, host_oe_n});
    do_write(15'h0000, 8'ha5);
    do_write(15'h7fff, 8'h3c);
    do_write(15'h5555, 8'hff);
    do_write(15'h2aaa, 8'h00);
    do_read(15'h0000, 8'ha5);
    do_read(15'h7fff, 8'h3c);
    do_read(15'h5555, 8'hff);
    do_read(15'h2aaa, 8'h00);
    do_write(15'h0000, 8'h5a);
    do_read(15'h0000, 8'h5a);
    do_retain();
    do_read(15'h7fff, 8'h3c);
    end_of_test();
  end
endmodule : asram_host_tb_top
`default_nettype wire

/* File: testbench/asram_ram_model.sv */
// Behavioural 32K x 8 static RAM standing on the far side of the host's pins.
// Assumes the bench resolves the shared data bus and feeds the level back in.
`timescale 1ns/1ps
`default_nettype none

module asram_ram_model
  (
    input wire asram_pkg::asram_pins_t pins_in,
    input wire logic [asram_pkg::DATA_W-1:0] bus_in,
    output logic [asram_pkg::DATA_W-1:0] dout_out,
    output logic drive_out
  );
  import asram_pkg::*;
  // ==========================================================
  // Array and pin decode
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  wire logic sel = !pins_in.chip_select_n;
  wire logic wr_act = sel && !pins_in.read_write;
  // Read mode only; standby, deselect and any write leave the bus floating
  assign drive_out = sel && !pins_in.output_enable_n && pins_in.read_write;
  // Select and enable fall together, so select access time bounds the byte; old byte stays meanwhile
  // Released bus shows the inverse, so a host that samples too early sees a wrong byte
  initial dout_out = 8'h00;
  always @(drive_out or pins_in.word_address)
  begin
    if (drive_out)
      dout_out <= #(ACCESS_NS_FAST) mem[pins_in.word_address];
    else
      dout_out <= ~dout_out;
  end
  // Store at the end of the overlap, whichever pin rises first
  always @(negedge wr_act)
    mem[pins_in.word_address] <= bus_in;
endmodule : asram_ram_model
`default_nettype wire

/* File: verilog/asram_host.sv */
// Host controller driving a 32K x 8 asynchronous static RAM over its pins.
// Assumes the RAM pins are wired directly; the data bus is resolved outside.
// Operation
// RL1: The RAM holds 32,768 bytes, each picked by a 15-bit word address.
// RL2: With chip select high the RAM is in standby and its data lines float.
// RL3: During a read the host keeps read/write high while chip select and output enable are low.
// RL4: Chip select low with output enable and read/write high leaves the data lines floating.
// RL5: Chip select low with read/write low stores the data-line byte, output enable ignored.
// RL6: If chip select falls with or after read/write, the RAM never drives during that write.
// RL7: If chip select rises with or before read/write, the RAM outputs stay floating.
// RL8: Output enable high during any part of a write keeps the RAM outputs floating.
// RL9: Read data is valid within 45 ns (fast) or 50 ns (slow) after output enable falls.
// RL10: The host keeps chip select low at least 65 ns or 90 ns before a write ends.
// RL11: Old read data stays valid at least 10 ns after an address change.
// RL12: The host deselects the RAM no later than the start of supply reduction.
// RL13: After leaving retention the host waits one read cycle time before any access.
// RL14: Chip select both selects the RAM and governs retention entry and exit.
// RL15: A write lasts while chip select and read/write are both low and ends at the first rise.
`timescale 1ns/1ps
`default_nettype none

module asram_host
  #(
    parameter bit SLOW_GRADE = 1'b0
  )
  (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // User side
    input wire logic req_valid_in,
    input wire asram_pkg::asram_req_t req_in,
    output logic req_ready_out,
    output logic [asram_pkg::DATA_W-1:0] rdata_out,
    output logic rdata_valid_out,
    input wire logic retain_in,
    output logic retained_out,
    // RAM pins
    output var asram_pkg::asram_pins_t pins_out,
    input wire logic [asram_pkg::DATA_W-1:0] data_lines_in,
    output logic [asram_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe_n_out
  );
  import asram_pkg::*;

  // ==========================================================
  // Grade selection
  localparam logic [CNT_W-1:0] RD_WAIT = SLOW_GRADE ? READ_WAIT_CYC_SLOW : READ_WAIT_CYC_FAST;
  localparam logic [CNT_W-1:0] RD_CYCLE = SLOW_GRADE ? READ_CYCLE_CYC_SLOW : READ_CYCLE_CYC_FAST;
  localparam logic [CNT_W-1:0] WR_LOW = SLOW_GRADE ? WRITE_LOW_CYC_SLOW : WRITE_LOW_CYC_FAST; // [RL10]
  localparam logic [CNT_W-1:0] CW_MIN = SLOW_GRADE ? SELECT_TO_WRITE_END_CYC_SLOW : SELECT_TO_WRITE_END_CYC_FAST;

  asram_state_t state;
  asram_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [DATA_W-1:0] sync1;
  logic [DATA_W-1:0] sync2;
  logic [DATA_W-1:0] sync3;

  // ==========================================================
  // Data pin synchroniser; only stages two and three are compared
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= data_lines_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ==========================================================
  // Decode
  wire idle = (state == ST_IDLE);
  wire cnt_done = (cnt == CNT_ZERO);
  wire data_stable = (sync2 == sync3);
  wire take_req = idle && req_valid_in && !retain_in;
  wire enter_retain = idle && retain_in; // Retention wins over a pending access
  wire read_capture = (state == ST_READ) && cnt_done && data_stable;
  // Held address keeps previous data valid well past hold time [RL11]
  assign req_ready_out = idle && !retain_in;
  assign retained_out = (state == ST_RETAIN);

  // ==========================================================
  // Next state and counter
  always_comb
  begin
    next_state = state;
    next_cnt = cnt_done ? CNT_ZERO : cnt - CNT_ONE;
    case (state)
      ST_IDLE:
      begin
        if (enter_retain)
          next_state = ST_RETAIN; // Chip select already high here [RL12] [RL14]
        else if (take_req)
        begin
          next_state = req_in.write ? ST_WRITE : ST_READ;
          next_cnt = req_in.write ? WR_LOW - CNT_ONE : RD_WAIT - CNT_ONE;
        end
      end
      ST_READ:
      begin
        // Unstable bus sample gets one more cycle rather than a bad byte [RL9]
        if (read_capture)
          next_state = ST_IDLE;
      end
      ST_WRITE:
      begin
        if (cnt_done)
          next_state = ST_WRITE_END; // Both strobes rise together [RL15]
      end
      ST_WRITE_END:
        next_state = ST_IDLE;
      ST_RETAIN:
      begin
        if (!retain_in)
        begin
          next_state = ST_RECOVER;
          next_cnt = RD_CYCLE - CNT_ONE;
        end
      end
      ST_RECOVER:
      begin
        if (cnt_done)
          next_state = ST_IDLE; // One read cycle time before access [RL13]
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // State, pins and data registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      pins_out <= {{ADDR_W{1'b0}}, PIN_CE_N_RST, PIN_OE_N_RST, PIN_RW_RST};
      data_lines_out <= '0;
      data_lines_oe_n_out <= 1'b1;
      rdata_out <= '0;
      rdata_valid_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      rdata_valid_out <= read_capture;
      if (read_capture)
        rdata_out <= sync3;
      if (take_req)
      begin
        pins_out.word_address <= req_in.addr; // 15-bit word address [RL1]
        data_lines_out <= req_in.wdata;
      end
      // Select and strobe levels follow the next state
      pins_out.chip_select_n <= !(next_state == ST_READ || next_state == ST_WRITE); // [RL2] [RL15]
      pins_out.output_enable_n <= !(next_state == ST_READ); // High through writes [RL8] [RL5]
      pins_out.read_write <= !(next_state == ST_WRITE); // Stays high in reads [RL3]
      // Data held through the rising strobes for zero hold time
      data_lines_oe_n_out <= !(next_state == ST_WRITE || next_state == ST_WRITE_END);
    end
  end

  // ==========================================================
  // Helper counters for checks
  logic [CNT_W-1:0] sel_low_cnt;
  logic [CNT_W-1:0] since_retain;
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sel_low_cnt <= CNT_ZERO;
      since_retain <= 4'hf;
    end
    else
    begin
      sel_low_cnt <= pins_out.chip_select_n ? CNT_ZERO :
        ((sel_low_cnt == 4'hf) ? sel_low_cnt : sel_low_cnt + CNT_ONE);
      since_retain <= retained_out ? CNT_ZERO :
        ((since_retain == 4'hf) ? since_retain : since_retain + CNT_ONE);
    end
  end

  // ==========================================================
  // Assertions
  chk_read_rw_high: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RL3]
    (!pins_out.chip_select_n && !pins_out.output_enable_n) |-> pins_out.read_write)
    else $error("read/write low while reading");

  chk_no_bus_fight: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RL8]
    !pins_out.output_enable_n |-> data_lines_oe_n_out)
    else $error("host drives data while RAM output enabled");

  chk_write_select_len: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RL10]
    ($rose(pins_out.chip_select_n) && !$past(pins_out.read_write)) |-> ($past(sel_low_cnt) >= CW_MIN - CNT_ONE))
    else $error("chip select low too short before write end");

  chk_write_end_joint: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RL15]
    $rose(pins_out.read_write) |-> $rose(pins_out.chip_select_n) ##1 data_lines_oe_n_out)
    else $error("write strobes did not end together");

  chk_retain_deselect: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RL12]
    retained_out |-> pins_out.chip_select_n)
    else $error("selected during retention");

  chk_recover_wait: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RL13]
    $fell(pins_out.chip_select_n) |-> (since_retain > RD_CYCLE))
    else $error("access too soon after retention");

  chk_read_answer: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RL9]
    (take_req && !req_in.write) |-> ##[7:12] rdata_valid_out)
    else $error("read answer out of window");

  chk_write_oe_high: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RL8]
    !pins_out.read_write |-> pins_out.output_enable_n)
    else $error("output enable low during write");

endmodule : asram_host

`default_nettype wire

/* File: verilog/asram_pkg.sv */
// Constants and carrier types for the async static RAM host controller.
// Assumes a single 40 MHz clock; all pin timing is derived from it.
package asram_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  // ==========================================================
  // Clock and pin timing, nanoseconds as printed
  localparam int CLK_PERIOD_NS = 25;
  localparam int READ_CYCLE_NS_FAST = 85;
  localparam int READ_CYCLE_NS_SLOW = 100;
  localparam int ACCESS_NS_FAST = 85;
  localparam int ACCESS_NS_SLOW = 100;
  localparam int WRITE_CYCLE_NS_FAST = 85;
  localparam int WRITE_CYCLE_NS_SLOW = 100;
  localparam int WRITE_PULSE_NS_FAST = 60;
  localparam int WRITE_PULSE_NS_SLOW = 70;
  localparam int SELECT_TO_WRITE_END_NS_FAST = 65;
  localparam int SELECT_TO_WRITE_END_NS_SLOW = 90;
  localparam int DATA_SETUP_NS = 40;
  localparam int DESELECT_TO_RETENTION_NS = 0;

  // Least times round up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  function automatic int max3(input int a, input int b, input int c);
    int m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction : max3

  localparam int SYNC_STAGES = 3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] READ_CYCLE_CYC_FAST = CNT_W'(ns_to_cyc(READ_CYCLE_NS_FAST));
  localparam logic [CNT_W-1:0] READ_CYCLE_CYC_SLOW = CNT_W'(ns_to_cyc(READ_CYCLE_NS_SLOW));
  // Access wait plus the pin synchroniser depth
  localparam logic [CNT_W-1:0] READ_WAIT_CYC_FAST = CNT_W'(ns_to_cyc(ACCESS_NS_FAST) + SYNC_STAGES);
  localparam logic [CNT_W-1:0] READ_WAIT_CYC_SLOW = CNT_W'(ns_to_cyc(ACCESS_NS_SLOW) + SYNC_STAGES);
  // Strobe low time covers pulse width, select-to-end and cycle time less the write-end cycle
  localparam logic [CNT_W-1:0] WRITE_LOW_CYC_FAST = CNT_W'(max3(ns_to_cyc(WRITE_PULSE_NS_FAST),
    ns_to_cyc(SELECT_TO_WRITE_END_NS_FAST), ns_to_cyc(WRITE_CYCLE_NS_FAST) - 1));
  localparam logic [CNT_W-1:0] WRITE_LOW_CYC_SLOW = CNT_W'(max3(ns_to_cyc(WRITE_PULSE_NS_SLOW),
    ns_to_cyc(SELECT_TO_WRITE_END_NS_SLOW), ns_to_cyc(WRITE_CYCLE_NS_SLOW) - 1));
  localparam logic [CNT_W-1:0] SELECT_TO_WRITE_END_CYC_FAST = CNT_W'(ns_to_cyc(SELECT_TO_WRITE_END_NS_FAST));
  localparam logic [CNT_W-1:0] SELECT_TO_WRITE_END_CYC_SLOW = CNT_W'(ns_to_cyc(SELECT_TO_WRITE_END_NS_SLOW));
  localparam logic [CNT_W-1:0] DATA_SETUP_CYC = CNT_W'(ns_to_cyc(DATA_SETUP_NS));
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // Pin levels after reset: deselected, read direction, bus released
  localparam logic PIN_CE_N_RST = 1'b1;
  localparam logic PIN_OE_N_RST = 1'b1;
  localparam logic PIN_RW_RST = 1'b1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] word_address;
    logic chip_select_n;
    logic output_enable_n;
    logic read_write;
  } asram_pins_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asram_req_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_WRITE_END,
    ST_RETAIN,
    ST_RECOVER
  } asram_state_t;

endpackage : asram_pkg
